// [smt_timer.v]
// Signal measurement timer core with register port
`timescale 1ns/10ps
`include "smt_map.vh"
module smt_timer #(
  parameter CW = 24
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          ce,
  input  wire [3:0]    addr,
  input  wire [31:0]   wdata,
  input  wire          wr,
  input  wire          rd,
  output reg  [31:0]   rdata,
  input  wire [4:0]    clk_sources,
  input  wire          measured_signal,
  input  wire          window_input,
  output reg           period_match_irq,
  output reg           width_capture_flag,
  output reg           period_capture_flag
);

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  reg [7:0]    con0_r;
  reg [8:0]    con1_r;
  reg [2:0]    clock_source_field_r;
  reg [CW-1:0] measure_counter_r;
  reg [CW-1:0] period_match_value_r;
  reg [CW-1:0] pulse_width_latch_r;
  reg [CW-1:0] period_latch_r;
  reg          run_flag_r;

  wire [1:0] prescale_field = con0_r[1:0];
  wire       halt_at_match  = con0_r[`SMT_C0_HALT];
  wire       enable         = con0_r[`SMT_C0_EN];
  wire [3:0] mode           = con1_r[3:0];
  wire       repeat_en      = con1_r[`SMT_C1_REP];
  wire       run_request    = con1_r[`SMT_C1_GO];
  wire       wide16         = con1_r[`SMT_C1_W16];

  function [CW-1:0] smt_trim;
    input [CW-1:0] v;
    input          w16;
    begin
      smt_trim = w16 ? (v & `SMT_MASK16) : v;
    end
  endfunction

  // -------------------------------------------------------------------
  // Clock selection and prescaler (tick enable on clk)
  // -------------------------------------------------------------------
  // Sources arrive as levels from other domains; two flops before use
  reg [4:0] src_m_r;
  reg [4:0] src_s_r;
  reg       src_d_r;
  reg [7:0] pre_r;
  wire sel_raw = (clock_source_field_r < 3'd5) ?
                 src_s_r[clock_source_field_r] : 1'b0;
  wire sel_lvl = sel_raw ^ con0_r[`SMT_C0_CINV];
  wire src_edge = sel_lvl & ~src_d_r;
  wire [7:0] pre_max = (prescale_field == 2'd0) ? 8'h00 :
                       (prescale_field == 2'd1) ? 8'h01 :
                       (prescale_field == 2'd2) ? 8'h03 : 8'h07;
  wire tick = src_edge && (pre_r >= pre_max);

  always @(posedge clk) begin
    if (rst) begin
      src_m_r <= 5'h00;
      src_s_r <= 5'h00;
      src_d_r <= 1'b0;
      pre_r   <= 8'h00;
    end else if (ce) begin
      src_m_r <= clk_sources;
      src_s_r <= src_m_r;
      src_d_r <= sel_lvl;
      if (tick)
        pre_r <= 8'h00;
      else if (src_edge)
        pre_r <= pre_r + 8'h01;
    end
  end

  // -------------------------------------------------------------------
  // Input synchronisers, first flop on clk, the rest stepped on the timer tick
  // -------------------------------------------------------------------
  reg sig_m_r, sig_s_r, sig_d_r;
  reg win_m_r, win_s_r, win_d_r;
  reg go_s_r;
  wire sig_act  = sig_s_r ^ con0_r[`SMT_C0_SINV];
  wire win_act  = win_s_r ^ con0_r[`SMT_C0_WINV];
  wire sig_rise = sig_act & ~sig_d_r;
  wire sig_fall = ~sig_act & sig_d_r;
  always @(posedge clk) begin
    if (rst) begin
      sig_m_r <= 1'b0; sig_s_r <= 1'b0; sig_d_r <= 1'b0;
      win_m_r <= 1'b0; win_s_r <= 1'b0; win_d_r <= 1'b0;
      go_s_r  <= 1'b0;
    end else if (ce) begin
      sig_m_r <= measured_signal;
      win_m_r <= window_input;
      if (tick) begin
        sig_s_r <= sig_m_r;
        win_s_r <= win_m_r;
        sig_d_r <= sig_act;
        win_d_r <= win_act;
        go_s_r  <= run_request & enable;
      end
    end
  end

  // -------------------------------------------------------------------
  // Counter, match and acquisition
  // -------------------------------------------------------------------
  wire [CW-1:0] cnt   = smt_trim(measure_counter_r, wide16);
  wire [CW-1:0] per   = smt_trim(period_match_value_r, wide16);
  wire          match = (cnt == per);
  wire          running = go_s_r;
  wire          sync_mode = ~mode[3];

  reg           cnt_inc, cnt_zero, cnt_one, cap_w, cap_p, stop_go;
  // First rise latches a period but cannot stop the run; the second one can end a single acquisition
  reg           armed_r;
  always @* begin
    cnt_inc  = 1'b0;
    cnt_zero = 1'b0;
    cnt_one  = 1'b0;
    cap_w    = 1'b0;
    cap_p    = 1'b0;
    stop_go  = 1'b0;
    if (tick && running && sync_mode) begin
      case (mode)
        `SMT_M_TIMER: begin
          cnt_inc = 1'b1;
        end
        `SMT_M_GATED: begin
          cnt_inc = sig_act;
          cap_w   = sig_fall;
          stop_go = sig_fall & ~repeat_en;
        end
        `SMT_M_PERDUTY: begin
          cnt_inc = 1'b1;
          cap_w   = sig_fall;
          if (sig_rise) begin
            cap_p   = 1'b1;
            cnt_one = 1'b1;
            stop_go = ~repeat_en & armed_r;
          end
        end
        default: begin
          cnt_inc = 1'b1;
        end
      endcase
      if (match && !cnt_one) begin
        cnt_inc  = 1'b0;
        cnt_zero = ~halt_at_match;
      end
    end
  end

  wire wr_tmr = wr && addr == `SMT_A_TMR;
  wire wr_st  = wr && addr == `SMT_A_STAT;
  wire rst_cnt = wr_st && wdata[`SMT_ST_RST];
  wire sw_cpw  = wr_st && wdata[`SMT_ST_CPW];
  wire sw_cpr  = wr_st && wdata[`SMT_ST_CPR];

  always @(posedge clk) begin
    if (rst) begin
      measure_counter_r   <= {CW{1'b0}};
      pulse_width_latch_r <= {CW{1'b0}};
      period_latch_r      <= {CW{1'b0}};
      period_match_irq    <= 1'b0;
      width_capture_flag  <= 1'b0;
      period_capture_flag <= 1'b0;
      run_flag_r          <= 1'b0;
      armed_r             <= 1'b0;
    end else if (ce) begin
      if (!running)
        armed_r <= 1'b0;
      else if (tick && mode == `SMT_M_PERDUTY && sig_rise)
        armed_r <= 1'b1;
      width_capture_flag  <= cap_w | sw_cpw;
      period_capture_flag <= cap_p | sw_cpr;
      run_flag_r          <= go_s_r;
      if (tick && running && match)
        period_match_irq <= 1'b1;
      else if (!halt_at_match || rst_cnt || wr_tmr || !match)
        period_match_irq <= 1'b0;
      if (rst_cnt)
        measure_counter_r <= {CW{1'b0}};
      else if (wr_tmr)
        measure_counter_r <= smt_trim(wdata[CW-1:0], wide16);
      else if (cnt_one)
        measure_counter_r <= {{(CW-1){1'b0}}, 1'b1};
      else if (cnt_zero)
        measure_counter_r <= {CW{1'b0}};
      else if (cnt_inc)
        measure_counter_r <= smt_trim(cnt + 1'b1, wide16);
      if (cap_w || sw_cpw)
        pulse_width_latch_r <= cnt;
      if (cap_p || sw_cpr)
        period_latch_r <= cnt;
    end
  end

  // -------------------------------------------------------------------
  // Register port
  // -------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      con0_r               <= 8'h00;
      con1_r               <= 9'h000;
      clock_source_field_r <= 3'h0;
      period_match_value_r <= `SMT_PER_RST;
      rdata                <= 32'h0000_0000;
    end else if (ce) begin
      if (wr && addr == `SMT_A_CON0)
        con0_r <= {wdata[7], 1'b0, wdata[5:0]};
      if (wr && addr == `SMT_A_CON1)
        con1_r <= {wdata[8:6], 2'b00, wdata[3:0]};
      else if (stop_go)
        con1_r[`SMT_C1_GO] <= 1'b0;
      if (wr && addr == `SMT_A_CLK)
        clock_source_field_r <= wdata[2:0];
      if (wr && addr == `SMT_A_PER)
        period_match_value_r <= wdata[CW-1:0];
      rdata <= 32'h0000_0000;
      if (rd) begin
        case (addr)
          `SMT_A_CON0: rdata <= {24'h00_0000, con0_r};
          `SMT_A_CON1: rdata <= {23'h00_0000, con1_r};
          `SMT_A_STAT: rdata <= {29'h0000_0000, run_flag_r,
                                 sig_act & run_flag_r,
                                 win_act & run_flag_r};
          `SMT_A_CLK:  rdata <= {29'h0000_0000, clock_source_field_r};
          `SMT_A_TMR:  rdata <= {8'h00, cnt};
          `SMT_A_PER:  rdata <= {8'h00, period_match_value_r};
          `SMT_A_CPW:  rdata <= {8'h00, pulse_width_latch_r};
          `SMT_A_CPR:  rdata <= {8'h00, period_latch_r};
          `SMT_A_FLAG: rdata <= {31'h0000_0000, period_match_irq};
          default:     rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // smt_timer

// [smt_map.vh]
// Register map, field positions and constants of the measurement timer
// How it works
// - 24-bit up counter is the time base
// - Optional 16-bit counter width mode
// - 24-bit period match value, only low 16 bits compared in 16-bit mode
// - Three-bit field picks one of five clocks
// - Two-bit prescaler clocks counter and synchronisers
// - Match rolls counter to zero, raises interrupt
// - Clear bit forces counter to zero
// - Width latch loads on trigger or update bit
// - Period latch loads on trigger or update bit
// - Halt bit stops rollover, match flag persists
// - Polarity bits invert window, signal, clock
// - Window flag shows corrected window level while run flag set
// - Signal flag shows corrected signal level while run flag set
// - Run flag follows run request and enable, delayed
// - Single acquisition stops and clears run request
// - Four-bit mode field selects operating mode
// - Timer mode counts freely, match resets
// - Gated timer: signal gates, falling edge latches
// - Period mode: fall latches width, rise period
// - Single period acquisition clears run on second rise
// - Latch updates raise acquisition flags
// - Acquisition flags generated on timer clock
`ifndef SMT_MAP_VH
`define SMT_MAP_VH
`define SMT_A_CON0      4'h0
`define SMT_A_CON1      4'h1
`define SMT_A_STAT      4'h2
`define SMT_A_CLK       4'h3
`define SMT_A_TMR       4'h4
`define SMT_A_PER       4'h5
`define SMT_A_CPW       4'h6
`define SMT_A_CPR       4'h7
`define SMT_A_FLAG      4'h8
// Control zero: prescale[1:0] clk_inv 2 sig_inv 3 win_inv 4 halt 5 en 7
`define SMT_C0_CINV     2
`define SMT_C0_SINV     3
`define SMT_C0_WINV     4
`define SMT_C0_HALT     5
`define SMT_C0_EN       7
// Control one: mode[3:0] repeat 6 run 7 wide16 8
`define SMT_C1_REP      6
`define SMT_C1_GO       7
`define SMT_C1_W16      8
// Status write: width update 0, period update 1, clear 2
`define SMT_ST_CPW      0
`define SMT_ST_CPR      1
`define SMT_ST_RST      2
// Status read: window 0, signal 1, run 2
`define SMT_ST_WS       0
`define SMT_ST_AS       1
`define SMT_ST_TS       2
`define SMT_M_TIMER     4'h0
`define SMT_M_GATED     4'h1
`define SMT_M_PERDUTY   4'h2
`define SMT_M_HILO      4'h3
`define SMT_M_WIN       4'h4
`define SMT_M_GWIN      4'h5
`define SMT_M_TOF       4'h6
`define SMT_M_CAPT      4'h7
`define SMT_M_CNT       4'h8
`define SMT_M_GCNT      4'h9
`define SMT_M_WCNT      4'hA
`define SMT_PER_RST     24'hFF_FFFF
`define SMT_MASK16      24'h00_FFFF
`endif

// [smt_timer_sva.sv]
// Port-level assertions for the measurement timer
`timescale 1ns/10ps
module smt_timer_sva (
  input wire        clk,
  input wire        rst,
  input wire [3:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata,
  input wire        period_match_irq,
  input wire        width_capture_flag,
  input wire        period_capture_flag
);
  // ----------------------------------------
  // Shadow of the control bits we key on
  // ----------------------------------------
  reg halt_r;
  reg w16_r;
  reg per_w_r;
  always @(posedge clk) begin
    if (rst) begin
      halt_r  <= 1'b0;
      w16_r   <= 1'b0;
      per_w_r <= 1'b0;
    end else if (wr) begin
      if (addr == 4'h0) halt_r <= wdata[5];
      if (addr == 4'h1) w16_r <= wdata[8];
      if (addr == 4'h5) per_w_r <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  cnt_width_a: assert property (rd && addr == 4'h4
    |=> rdata[31:24] == 8'h00) else $error("counter above 24 bits");
  per_reset_a: assert property (rd && addr == 4'h5 && !per_w_r
    |=> rdata == 32'h00FF_FFFF) else $error("period reset value");
  upper_zero_a: assert property (rd && addr == 4'h4 && w16_r
    |=> rdata[23:16] == 8'h00) else $error("upper byte in 16-bit");
  cpw_update_a: assert property (wr && addr == 4'h2 && wdata[0]
    |-> ##[1:3] width_capture_flag) else $error("no width flag");
  cpr_update_a: assert property (wr && addr == 4'h2 && wdata[1]
    |-> ##[1:3] period_capture_flag) else $error("no period flag");
  wflag_pulse_a: assert property (width_capture_flag
    |=> !width_capture_flag) else $error("width flag too long");
  pflag_pulse_a: assert property (period_capture_flag
    |=> !period_capture_flag) else $error("period flag too long");
  halt_hold_a: assert property (halt_r && period_match_irq && !wr
    && !$past(wr) |=> period_match_irq) else $error("halt irq dropped");
endmodule // smt_timer_sva
bind smt_timer smt_timer_sva chk_u (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .period_match_irq(period_match_irq),
  .width_capture_flag(width_capture_flag),
  .period_capture_flag(period_capture_flag));

// [smt_src_model.sv]
// Far-side model: clock sources, measured signal and window
`timescale 1ns/10ps
module smt_src_model (
  input  wire       clk,
  input  wire       rst,
  input  wire       sig_lvl,
  input  wire       win_lvl,
  output reg  [4:0] clk_sources = 5'h00,
  output reg        measured_signal = 1'b0,
  output reg        window_input = 1'b0
);
  // Binary counter: five sources at clk/2 down to clk/32
  always @(posedge clk) begin
    if (rst)
      clk_sources <= 5'h00;
    else
      clk_sources <= clk_sources + 5'h01;
    measured_signal <= sig_lvl;
    window_input    <= win_lvl;
  end
endmodule // smt_src_model

// [tb_signal_measurement_timer.sv]
// Self-checking bench for the measurement timer
`timescale 1ns/10ps
`include "smt_map.vh"
module tb_signal_measurement_timer;
  reg         clk;
  reg         rst;
  reg  [3:0]  addr;
  reg  [31:0] wdata;
  reg         wr;
  reg         rd;
  reg         sig_lvl;
  reg         win_lvl;
  wire [31:0] rdata;
  wire [4:0]  srcs;
  wire        msig;
  wire        win;
  wire        irq;
  wire        wflag;
  wire        pflag;
  reg  [31:0] d;
  reg  [31:0] w;
  integer     errors;
  integer     checks_done;
  integer     wcnt;
  integer     pcnt;
  integer     hi;
  smt_src_model src_u (.clk(clk), .rst(rst), .sig_lvl(sig_lvl),
    .win_lvl(win_lvl), .clk_sources(srcs), .measured_signal(msig),
    .window_input(win));
  smt_timer dut_u (.clk(clk), .rst(rst), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .clk_sources(srcs),
    .measured_signal(msig), .window_input(win), .period_match_irq(irq),
    .width_capture_flag(wflag), .period_capture_flag(pflag));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wflag === 1'b1) wcnt = wcnt + 1;
    if (pflag === 1'b1) pcnt = pcnt + 1;
    if (irq === 1'b1) hi = hi + 1;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wreg(input [3:0] a, input [31:0] v);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [3:0] a);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask
  task sig_for(input v, input integer n);
    begin
      sig_lvl <= v;
      repeat (n) @(posedge clk);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_latches;
    begin
      rreg(`SMT_A_PER);
      chk(d, 32'h00FF_FFFF);
      wreg(`SMT_A_TMR, 32'h0012_3456);
      wreg(`SMT_A_STAT, 32'h0000_0001);
      rreg(`SMT_A_CPW);
      chk(d, 32'h0012_3456);
      wreg(`SMT_A_STAT, 32'h0000_0002);
      rreg(`SMT_A_CPR);
      chk(d, 32'h0012_3456);
      wreg(`SMT_A_STAT, 32'h0000_0004);
      rreg(`SMT_A_TMR);
      chk(d, 32'h0000_0000);
    end
  endtask
  task t_halt;
    begin
      wreg(`SMT_A_PER, 32'h0000_0003);
      wreg(`SMT_A_CON0, 32'h0000_00A0);
      wreg(`SMT_A_CON1, 32'h0000_00C0);
      sig_for(1'b1, 40);
      chk(irq, 1'b1);
      rreg(`SMT_A_TMR);
      chk(d, 32'h0000_0003);
      rreg(`SMT_A_STAT);
      chk(d[2:1], 2'h3);
      wreg(`SMT_A_CON0, 32'h0000_0088);
      sig_for(1'b1, 10);
      rreg(`SMT_A_STAT);
      chk(d[1], 1'b0);
      hi = 0;
      sig_for(1'b0, 40);
      chk(hi > 0 && hi < 40, 1'b1);
      wreg(`SMT_A_CON1, 32'h0000_0000);
      sig_for(1'b0, 6);
      rreg(`SMT_A_STAT);
      chk(d[2], 1'b0);
    end
  endtask
  task t_wide16;
    begin
      wreg(`SMT_A_CON1, 32'h0000_0100);
      wreg(`SMT_A_TMR, 32'h0012_FFFE);
      wreg(`SMT_A_CON1, 32'h0000_01C0);
      sig_for(1'b0, 20);
      wreg(`SMT_A_CON1, 32'h0000_0100);
      rreg(`SMT_A_TMR);
      chk(d[23:16], 8'h00);
    end
  endtask
  task t_period;
    begin
      wreg(`SMT_A_CON0, 32'h0000_0080);
      wreg(`SMT_A_PER, 32'h00FF_FFFF);
      wcnt = 0;
      pcnt = 0;
      wreg(`SMT_A_CON1, 32'h0000_0082);
      sig_for(1'b0, 10);
      repeat (2) begin
        sig_for(1'b1, 20);
        sig_for(1'b0, 20);
      end
      sig_for(1'b1, 20);
      rreg(`SMT_A_CON1);
      chk(d[7], 1'b0);
      chk(wcnt > 0 && pcnt > 0, 1'b1);
      rreg(`SMT_A_CPW);
      w = d;
      rreg(`SMT_A_CPR);
      // Tick every 2 cycles: 20 high, 40 period, sync slack
      chk(w > 7 && w < 13 && d > 17 && d < 23, 1'b1);
    end
  endtask
  task t_gated;
    begin
      win_lvl <= 1'b1;
      wreg(`SMT_A_STAT, 32'h0000_0004);
      wreg(`SMT_A_CON1, 32'h0000_00C1);
      sig_for(1'b0, 10);
      sig_for(1'b1, 20);
      sig_for(1'b0, 10);
      rreg(`SMT_A_STAT);
      chk(d[0], 1'b1);
      rreg(`SMT_A_CPW);
      w = d;
      rreg(`SMT_A_TMR);
      chk(w > 7 && w < 13, 1'b1);
      chk(d, w);
      wreg(`SMT_A_CON1, 32'h0000_0000);
    end
  endtask
  task end_of_test;
    begin
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #200000;
    errors = errors + 1;
    end_of_test;
  end
  initial begin
    {rst, wr, rd, sig_lvl} = 4'h8;
    win_lvl = 1'b0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    {errors, checks_done, wcnt, pcnt, hi} = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_latches;
    t_halt;
    t_wide16;
    t_period;
    t_gated;
    end_of_test;
  end
endmodule // tb_signal_measurement_timer
